// ===== hw/mcpc_clkdiv.sv
// mcu clock enable: 16 MHz average pulse rate divided by a power of two
// assumes a 100 MHz mclk_i; pulses only while run_i is high
`timescale 1ns/1ps
`default_nettype none
`include "mcpc_regs.svh"
module mcpc_clkdiv (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic [2:0] div_i,
    output logic tick_o
);
    // =====================================================
    // fractional base rate
    // 16 of every 100 cycles carry a base pulse; jitter traded for no pll
    localparam logic [7:0] STEP = 8'(`MCPC_BASE_MHZ);
    localparam logic [7:0] MODV = 8'(`MCPC_CLK_MHZ);
    logic [6:0] acc_reg;
    logic [6:0] cnt_reg;
    logic tick_reg;
    function automatic logic [6:0] div_mask(input logic [2:0] d);
        div_mask = 7'((8'h01 << d) - 8'h01);
    endfunction
    wire logic [7:0] acc_sum = {1'b0, acc_reg} + STEP;
    wire logic base_tick = acc_sum >= MODV;
    wire logic [6:0] acc_next = base_tick ? 7'(acc_sum - MODV) : acc_sum[6:0];
    wire logic [6:0] cnt_next = 7'(cnt_reg + 7'h01);
    wire logic [6:0] mask = div_mask(div_i);
    // =====================================================
    // power-of-two divider
    // halving per code
    wire logic hit = base_tick && ((cnt_reg & mask) == mask);
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_reg <= 7'h00;
            cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            if (base_tick) begin
                cnt_reg <= cnt_next;
            end
            tick_reg <= run_i && hit;
        end
    end
    assign tick_o = tick_reg;
endmodule
`default_nettype wire

// ===== hw/mcpc_pkg.sv
// types shared by the clock and power-down control block
// assumes the constants of mcpc_regs.svh
package mcpc_pkg;
    // =====================================================
    // clock configuration register layout
    typedef struct packed {
        logic keep_xtal;
        logic bypass;
        logic [1:0] osc_start;
        logic xtal_wake_en;
        logic [2:0] div;
    } mcpc_clkcfg_t;
    // =====================================================
    // wakeup source flags
    typedef struct packed {
        logic pin;
        logic tick;
        logic comp;
    } mcpc_wake_t;
    typedef enum logic [1:0] {SRC_RC, SRC_XTAL, SRC_PIN} mcpc_src_t;
    typedef enum logic [1:0] {ST_ACTIVE, ST_DOWN, ST_WAKE} mcpc_state_t;
endpackage

// ===== hw/mcpc_regs.svh
// register map, field positions, codes and timing counts of the clock block
// assumes a 100 MHz mclk_i and 8-bit registers placed in 32-bit apb words
`ifndef MCPC_REGS_SVH
`define MCPC_REGS_SVH
// =====================================================
// register indices and byte addresses
`define MCPC_ADDR_W 12
`define MCPC_IDX_CLKCFG 8'ha3
`define MCPC_IDX_PWRDN 8'ha4
`define MCPC_IDX_LFCTL 8'had
`define MCPC_ADDR_CLKCFG {2'h0, `MCPC_IDX_CLKCFG, 2'h0}
`define MCPC_ADDR_PWRDN {2'h0, `MCPC_IDX_PWRDN, 2'h0}
`define MCPC_ADDR_LFCTL {2'h0, `MCPC_IDX_LFCTL, 2'h0}
// =====================================================
// reset values
`define MCPC_RST_CLKCFG 8'h00
`define MCPC_RST_PWRDN 8'h00
`define MCPC_RST_LFCTL 8'h07
// =====================================================
// field positions and synchroniser width
`define MCPC_PD_FLAG_HI 7
`define MCPC_PD_FLAG_LO 5
`define MCPC_LF_PHASE 7
`define MCPC_LF_READY 6
`define MCPC_LF_XACT 3
`define MCPC_NSYNC 9
// =====================================================
// oscillator start codes
`define MCPC_START_BOTH 2'h0
`define MCPC_START_RC 2'h1
`define MCPC_START_XTAL 2'h2
`define MCPC_START_RSV 2'h3
// =====================================================
// low-frequency source codes
`define MCPC_LFS_SXTAL 3'h0
`define MCPC_LFS_SRC 3'h1
`define MCPC_LFS_SYNTH 3'h2
`define MCPC_LFS_APIN 3'h3
`define MCPC_LFS_DIG 3'h4
`define MCPC_LFS_NONE 3'h7
// =====================================================
// power-down codes
`define MCPC_PM_OFF 3'h0
`define MCPC_PM_DEEP 3'h1
`define MCPC_PM_MRET_OFF 3'h2
`define MCPC_PM_MRET_ON 3'h3
`define MCPC_PM_RRET 3'h4
`define MCPC_PM_RSV5 3'h5
`define MCPC_PM_RSV6 3'h6
`define MCPC_PM_STBY 3'h7
// =====================================================
// timing
`define MCPC_CLK_PERIOD_NS 10
`define MCPC_CLK_MHZ 100
`define MCPC_BASE_MHZ 16
`define MCPC_LF_HALF_NS 15259
`define MCPC_LF_HALF_CYC (`MCPC_LF_HALF_NS / `MCPC_CLK_PERIOD_NS)
`endif

// ===== hw/mcpc_top.sv
// mcu clock source, clock divider, low-frequency clock and power-down control
// assumes an apb master on mclk_i; oscillator, clock and wakeup inputs are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "mcpc_regs.svh"
// =====================================================
module mcpc_top (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`MCPC_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic fast_crystal_ready_i,
    input wire logic fast_rc_ready_i,
    input wire logic slow_crystal_clk_i,
    input wire logic slow_rc_clk_i,
    input wire logic lf_analog_pin_clk_i,
    input wire logic lf_digital_pin_clk_i,
    input wire logic wake_pin_i,
    input wire logic wake_tick_i,
    input wire logic wake_comp_i,
    output logic fast_crystal_osc_en_o,
    output logic fast_rc_osc_en_o,
    output var mcpc_pkg::mcpc_src_t sys_clk_src_o,
    output logic mcu_clk_en_o,
    output logic fast_crystal_ready_irq_o,
    output logic [2:0] low_freq_clock_sel_o,
    output logic low_freq_clock_o,
    output logic timers_on_o,
    output logic cpu_halt_o,
    output logic wake_reset_o,
    output logic [2:0] power_mode_o
);
    // =====================================================
    // helpers
    function automatic logic is_deep_ret(input logic [2:0] m);
        is_deep_ret = (m == `MCPC_PM_DEEP) || (m == `MCPC_PM_MRET_OFF) || (m == `MCPC_PM_MRET_ON);
    endfunction
    function automatic logic is_ret(input logic [2:0] m);
        is_ret = is_deep_ret(m) || (m == `MCPC_PM_RRET);
    endfunction
    function automatic logic valid_mode(input logic [2:0] m);
        valid_mode = (m != `MCPC_PM_OFF) && (m != `MCPC_PM_RSV5) && (m != `MCPC_PM_RSV6);
    endfunction

    // =====================================================
    // state
    mcpc_pkg::mcpc_clkcfg_t cc_reg;
    mcpc_pkg::mcpc_wake_t flags_reg;
    mcpc_pkg::mcpc_wake_t flags_next;
    mcpc_pkg::mcpc_state_t state_reg;
    mcpc_pkg::mcpc_state_t state_next;
    mcpc_pkg::mcpc_src_t src_reg;
    logic [`MCPC_NSYNC-1:0] sync1_reg;
    logic [`MCPC_NSYNC-1:0] sync2_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [2:0] prev_mode_reg;
    logic [2:0] mode_reg;
    logic [1:0] start_act_reg;
    logic [2:0] lf_sel_reg;
    logic xtal_en_reg;
    logic rc_en_reg;
    logic xtal_act_reg;
    logic xtal_rdy_d_reg;
    logic irq_reg;
    logic lf_phase_reg;
    logic lf_ready_reg;
    logic synth_reg;
    logic [10:0] synth_cnt_reg;
    logic timers_reg;
    logic halt_reg;
    logic wake_rst_reg;

    // =====================================================
    // input synchronisers
    wire logic [`MCPC_NSYNC-1:0] async_in = {
        fast_crystal_ready_i, fast_rc_ready_i, slow_crystal_clk_i, slow_rc_clk_i,
        lf_analog_pin_clk_i, lf_digital_pin_clk_i, wake_pin_i, wake_tick_i, wake_comp_i};
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire logic xtal_rdy_s = sync2_reg[8];
    wire logic rc_rdy_s = sync2_reg[7];
    wire logic [3:0] lf_clk_s = sync2_reg[6:3];
    wire mcpc_pkg::mcpc_wake_t wake_s = mcpc_pkg::mcpc_wake_t'(sync2_reg[2:0]);

    // =====================================================
    // apb slave, one wait state
    wire logic apb_acc = psel_i && penable_i;
    wire logic apb_first = apb_acc && !pready_reg;
    wire logic apb_done = apb_acc && pready_reg;
    wire logic hit_cc = paddr_i == `MCPC_ADDR_CLKCFG;
    wire logic hit_pd = paddr_i == `MCPC_ADDR_PWRDN;
    wire logic hit_lf = paddr_i == `MCPC_ADDR_LFCTL;
    wire logic hit_any = hit_cc || hit_pd || hit_lf;
    // writes land only on the completing edge, lane 0 carries the byte
    wire logic wr_lane = apb_done && pwrite_i && pstrb_i[0];
    wire logic wr_cc = wr_lane && hit_cc;
    wire logic wr_pd = wr_lane && hit_pd;
    wire logic wr_lf = wr_lane && hit_lf;
    wire logic rd_pd_done = apb_done && !pwrite_i && hit_pd;
    wire logic st_active = state_reg == mcpc_pkg::ST_ACTIVE;
    wire logic st_down = state_reg == mcpc_pkg::ST_DOWN;
    wire logic st_wake = state_reg == mcpc_pkg::ST_WAKE;

    // =====================================================
    // register read images
    // wakeup flag bits
    wire logic [7:0] pd_rd = {flags_reg, 2'h0, prev_mode_reg};
    wire logic [7:0] lf_rd = {lf_phase_reg, lf_ready_reg, 2'h0, xtal_act_reg, lf_sel_reg};
    wire logic [7:0] rd_mux = hit_cc ? cc_reg : (hit_pd ? pd_rd : (hit_lf ? lf_rd : 8'h00));
    wire logic [31:0] prdata_next = (apb_first && !pwrite_i) ? {24'h000000, rd_mux} : prdata_reg;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= apb_first;
            pslverr_reg <= apb_first && !hit_any;
        end
    end

    // =====================================================
    // power-down sequencing
    // valid nonzero code enters
    wire logic [2:0] wr_mode = pwdata_i[2:0];
    wire logic enter = wr_pd && st_active && valid_mode(wr_mode);
    wire logic xtal_rise = xtal_rdy_s && !xtal_rdy_d_reg;
    wire logic xtal_wake = cc_reg.xtal_wake_en && xtal_rise;
    wire logic wake_any = (|wake_s) || xtal_wake;
    wire logic [1:0] start_eff = (start_act_reg == `MCPC_START_RSV) ? `MCPC_START_BOTH : start_act_reg;
    wire logic run_xtal = start_eff != `MCPC_START_RC;
    wire logic run_rc = start_eff != `MCPC_START_XTAL;
    wire logic fast_ok = (start_eff == `MCPC_START_XTAL) ? xtal_rdy_s : rc_rdy_s;
    wire logic lf_active = lf_sel_reg <= `MCPC_LFS_DIG;
    wire logic lf_ok = !lf_active || lf_ready_reg;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mcpc_pkg::ST_ACTIVE: begin
                if (enter) begin
                    state_next = mcpc_pkg::ST_DOWN;
                end
            end
            mcpc_pkg::ST_DOWN: begin
                if (wake_any) begin
                    state_next = mcpc_pkg::ST_WAKE;
                end
            end
            mcpc_pkg::ST_WAKE: begin
                if (fast_ok && lf_ok) begin
                    state_next = mcpc_pkg::ST_ACTIVE;
                end
            end
            default: begin
                state_next = mcpc_pkg::ST_ACTIVE;
            end
        endcase
    end
    wire logic leave_down = st_down && wake_any;
    wire logic resume = st_wake && fast_ok && lf_ok;
    // clear on read or entry
    // a set in the clearing cycle still wins
    wire mcpc_pkg::mcpc_wake_t rd_clr = rd_pd_done ? mcpc_pkg::mcpc_wake_t'(prdata_reg[7:5]) : 3'h0;
    assign flags_next = (flags_reg & ~rd_clr & ~{3{enter}}) | (wake_s & {3{st_down}});
    wire logic timers_next = (state_next == mcpc_pkg::ST_DOWN) &&
        ((wr_mode == `MCPC_PM_MRET_ON && enter) || (!enter && mode_reg == `MCPC_PM_MRET_ON) ||
         ((enter ? wr_mode : mode_reg) == `MCPC_PM_RRET && lf_active));
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= mcpc_pkg::ST_ACTIVE;
            flags_reg <= 3'h0;
            prev_mode_reg <= `MCPC_PM_OFF;
            mode_reg <= `MCPC_PM_OFF;
            timers_reg <= 1'b0;
            halt_reg <= 1'b0;
            wake_rst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            flags_reg <= flags_next;
            timers_reg <= timers_next;
            halt_reg <= state_next != mcpc_pkg::ST_ACTIVE;
            wake_rst_reg <= resume && is_deep_ret(mode_reg);
            if (enter) begin
                prev_mode_reg <= wr_mode;
                mode_reg <= wr_mode;
            end else if (resume) begin
                mode_reg <= `MCPC_PM_OFF;
            end
        end
    end

    // =====================================================
    // fast oscillators and mcu clock source
    // crystal kept in standby, and in register retention when keep_xtal is set
    wire logic xtal_en_next = st_down ?
        (mode_reg == `MCPC_PM_STBY || (mode_reg == `MCPC_PM_RRET && cc_reg.keep_xtal)) : run_xtal;
    wire logic rc_en_next = st_down ? (mode_reg == `MCPC_PM_STBY) : run_rc;
    wire logic xtal_act_next = xtal_en_reg && xtal_rdy_s && run_xtal;
    wire mcpc_pkg::mcpc_src_t src_next = cc_reg.bypass ? mcpc_pkg::SRC_PIN :
        (xtal_act_reg ? mcpc_pkg::SRC_XTAL : mcpc_pkg::SRC_RC);
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cc_reg <= mcpc_pkg::mcpc_clkcfg_t'(`MCPC_RST_CLKCFG);
            start_act_reg <= `MCPC_START_BOTH;
            xtal_en_reg <= 1'b0;
            rc_en_reg <= 1'b0;
            xtal_act_reg <= 1'b0;
            xtal_rdy_d_reg <= 1'b0;
            irq_reg <= 1'b0;
            src_reg <= mcpc_pkg::SRC_RC;
        end else begin
            if (wr_cc) begin
                cc_reg <= mcpc_pkg::mcpc_clkcfg_t'(pwdata_i[7:0]);
            end
            if (leave_down && is_ret(mode_reg)) begin
                start_act_reg <= cc_reg.osc_start;
            end
            xtal_en_reg <= xtal_en_next;
            rc_en_reg <= rc_en_next;
            xtal_act_reg <= xtal_act_next;
            xtal_rdy_d_reg <= xtal_rdy_s;
            irq_reg <= xtal_rise && cc_reg.xtal_wake_en;
            src_reg <= src_next;
        end
    end

    // =====================================================
    // low-frequency clock
    // synthesized clock stops
    wire logic synth_run = xtal_act_reg && !(st_down && is_deep_ret(mode_reg));
    wire logic synth_wrap = synth_cnt_reg == 11'(`MCPC_LF_HALF_CYC - 1);
    wire logic [10:0] synth_cnt_next = synth_wrap ? 11'h000 : 11'(synth_cnt_reg + 11'h001);
    wire logic [7:0] lf_cand = {3'h0, lf_clk_s[0], lf_clk_s[1], synth_reg, lf_clk_s[2], lf_clk_s[3]};
    wire logic lf_mux = lf_cand[lf_sel_reg];
    // ready needs a seen edge; retested after every power-down
    wire logic lf_edge = lf_mux != lf_phase_reg;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lf_sel_reg <= 3'(`MCPC_RST_LFCTL);
            synth_cnt_reg <= 11'h000;
            synth_reg <= 1'b0;
            lf_phase_reg <= 1'b0;
            lf_ready_reg <= 1'b0;
        end else begin
            if (wr_lf) begin
                lf_sel_reg <= pwdata_i[2:0];
            end
            if (synth_run) begin
                synth_cnt_reg <= synth_cnt_next;
                synth_reg <= synth_reg ^ synth_wrap;
            end
            lf_phase_reg <= lf_mux;
            lf_ready_reg <= lf_edge || (lf_ready_reg && !wr_lf && !enter);
        end
    end

    // =====================================================
    // mcu clock divider
    mcpc_clkdiv u_div (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .run_i(st_active),
        .div_i(cc_reg.div),
        .tick_o(mcu_clk_en_o)
    );

    // =====================================================
    // outputs
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign fast_crystal_osc_en_o = xtal_en_reg;
    assign fast_rc_osc_en_o = rc_en_reg;
    assign sys_clk_src_o = src_reg;
    assign fast_crystal_ready_irq_o = irq_reg;
    assign low_freq_clock_sel_o = lf_sel_reg;
    assign low_freq_clock_o = lf_phase_reg;
    assign timers_on_o = timers_reg;
    assign cpu_halt_o = halt_reg;
    assign wake_reset_o = wake_rst_reg;
    assign power_mode_o = mode_reg;

    // =====================================================
    // assertions
    default clocking dcb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    a_keep_xtal_on: assert property (
        st_down && mode_reg == `MCPC_PM_RRET && cc_reg.keep_xtal |=> fast_crystal_osc_en_o)
        else $error("crystal dropped in retention");
    a_bypass_src: assert property (
        cc_reg.bypass ##1 cc_reg.bypass |-> sys_clk_src_o == mcpc_pkg::SRC_PIN)
        else $error("bypass not applied");
    a_auto_switch: assert property (
        xtal_act_reg && !cc_reg.bypass |=> sys_clk_src_o == mcpc_pkg::SRC_XTAL)
        else $error("no switch to crystal");
    a_start_latch: assert property (
        !$stable(start_act_reg) |-> $past(st_down) && is_ret($past(mode_reg)))
        else $error("start field applied early");
    a_xtal_irq: assert property (
        xtal_rise |=> fast_crystal_ready_irq_o == $past(cc_reg.xtal_wake_en))
        else $error("ready interrupt wrong");
    a_synth_stop: assert property (
        (st_down && is_deep_ret(mode_reg)) [*2] |-> $stable(synth_reg))
        else $error("derived clock ran in sleep");
    a_lf_wait: assert property (
        st_wake && lf_active && !lf_ready_reg |=> !st_active)
        else $error("woke without low-frequency clock");
    a_flag_clear: assert property (
        enter |=> flags_reg == 3'h0)
        else $error("flags survive entry");
    a_enter_mode: assert property (
        enter |=> st_down && power_mode_o == $past(wr_mode) && cpu_halt_o)
        else $error("mode not entered");
    a_prev_mode: assert property (
        apb_first && hit_pd && !pwrite_i |=> prdata_o[2:0] == $past(prev_mode_reg))
        else $error("previous mode readback wrong");
    a_no_reset_rret: assert property (
        st_wake && mode_reg == `MCPC_PM_RRET |=> !wake_reset_o)
        else $error("reset after register retention");
    c_deep_sleep: cover property (enter && wr_mode == `MCPC_PM_DEEP);
    c_rret_resume: cover property (resume && mode_reg == `MCPC_PM_RRET);
    c_ready_irq: cover property (fast_crystal_ready_irq_o);
    c_flag_read: cover property (rd_pd_done && prdata_reg[7:5] != 3'h0);
endmodule
`default_nettype wire

// ===== sim/mcpc_osc_model.sv
// oscillator model: each ready level follows its enable after a start-up delay
// assumes mcpc_top on the same mclk_i; slow rc and slow crystal run free
`timescale 1ns/1ps
`default_nettype none
module mcpc_osc_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic xtal_en_i,
    input wire logic rc_en_i,
    output logic xtal_rdy_o,
    output logic rc_rdy_o,
    output logic slow_rc_clk_o,
    output logic slow_xtal_clk_o
);
    // =====================================================
    // start-up counters
    logic [3:0] xcnt;
    logic [3:0] rcnt;
    logic [3:0] scnt;
    // crystal slower than rc, so the rc-first path is seen
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            xcnt <= 4'h0;
            rcnt <= 4'h0;
            scnt <= 4'h0;
        end else begin
            xcnt <= xtal_en_i ? (xcnt == 4'hf ? xcnt : xcnt + 4'h1) : 4'h0;
            rcnt <= rc_en_i ? (rcnt == 4'h3 ? rcnt : rcnt + 4'h1) : 4'h0;
            scnt <= scnt + 4'h1;
        end
    end
    assign rc_rdy_o = (rcnt == 4'h3);
    assign xtal_rdy_o = (xcnt == 4'hf);
    assign slow_rc_clk_o = scnt[3];
    assign slow_xtal_clk_o = scnt[2];
endmodule
`default_nettype wire

// ===== sim/mcpc_tb_top.sv
// bench: apb register tests, divider rate, low-freq ready, retention and pin wake
// assumes the oscillator model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "mcpc_regs.svh"
module mcu_clock_and_power_down_control_tb_top;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic wpin = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, xrdy, rrdy, srck, sxck, xen, ren, clken, halt, e, irq, lfo, wrst, tmr;
    logic [2:0] pmode, lfsel;
    logic [7:0] r;
    mcpc_pkg::mcpc_src_t src;
    int bad_count = 0;
    int checks = 0;
    int k;
    int irq_n = 0;
    int wrst_n = 0;
    int lf_n = 0;
    logic lfo_d = 1'b0;
    mcpc_top i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fast_crystal_ready_i(xrdy), .fast_rc_ready_i(rrdy),
        .slow_crystal_clk_i(sxck), .slow_rc_clk_i(srck), .lf_analog_pin_clk_i(1'b0),
        .lf_digital_pin_clk_i(1'b0), .wake_pin_i(wpin), .wake_tick_i(1'b0), .wake_comp_i(1'b0),
        .fast_crystal_osc_en_o(xen), .fast_rc_osc_en_o(ren), .sys_clk_src_o(src),
        .mcu_clk_en_o(clken), .fast_crystal_ready_irq_o(irq), .low_freq_clock_sel_o(lfsel),
        .low_freq_clock_o(lfo), .timers_on_o(tmr), .cpu_halt_o(halt), .wake_reset_o(wrst), .power_mode_o(pmode));
    mcpc_osc_model i_osc (.mclk_i(mclk_i), .nrst_i(nrst_i), .xtal_en_i(xen), .rc_en_i(ren),
        .xtal_rdy_o(xrdy), .rc_rdy_o(rrdy), .slow_rc_clk_o(srck), .slow_xtal_clk_o(sxck));
    // pulse and toggle counters for one-cycle outputs
    always @(posedge mclk_i) begin
        if (irq === 1'b1) irq_n++;
        if (wrst === 1'b1) wrst_n++;
        if (lfo !== lfo_d) lf_n++;
        lfo_d <= lfo;
    end
    // =====================================================
    // tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        checks++;
        if (got !== ex) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // hold the request until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("BAD pready expected 1 seen 0");
            summarize();
        end
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // 800 cycles at 100 MHz hold 128 pulses of 16 MHz
    task automatic pulses(input logic [2:0] d);
        int c;
        int ex;
        c = 0;
        ex = 128 >> d;
        xfer(1'b1, `MCPC_ADDR_CLKCFG, {5'h0, d});
        repeat (800) begin
            @(posedge mclk_i);
            if (clken === 1'b1) c++;
        end
        chk("mcu clock pulses", 8'(ex), 8'((c >= ex - 1 && c <= ex + 1) ? ex : c));
    endtask
    // enter a mode, then wake it by the pin
    task automatic nap(input logic [7:0] m);
        xfer(1'b1, `MCPC_ADDR_PWRDN, m);
        repeat (4) @(posedge mclk_i);
        chk("halt", 8'h01, {7'h0, halt});
        chk("power mode", m, {5'h0, pmode});
        chk("crystal kept", {7'h0, m == 8'h04}, {7'h0, xen});
        chk("timers on", {7'h0, m == 8'h04}, {7'h0, tmr});
        wpin <= 1'b1;
        k = 0;
        while (halt !== 1'b0 && k < 200) begin
            @(posedge mclk_i);
            k++;
        end
        wpin <= 1'b0;
        chk("resumed", 8'h00, {7'h0, halt});
        if (halt !== 1'b0) summarize();
    endtask
    // =====================================================
    // sequence
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        nrst_i <= 1'b1;
        xfer(1'b0, `MCPC_ADDR_CLKCFG, 8'h00);
        chk("clock config", 8'h00, r);
        xfer(1'b1, `MCPC_ADDR_CLKCFG, 8'h08);
        xfer(1'b0, `MCPC_ADDR_CLKCFG, 8'h00);
        chk("clock config rw", 8'h08, r);
        chk("osc enables", 8'h03, {6'h0, xen, ren});
        xfer(1'b0, `MCPC_ADDR_PWRDN, 8'h00);
        chk("power down", 8'h00, r);
        repeat (30) @(posedge mclk_i);
        chk("clock source", 8'(mcpc_pkg::SRC_XTAL), 8'(src));
        chk("ready irq", 8'h01, 8'(irq_n));
        xfer(1'b1, `MCPC_ADDR_CLKCFG, 8'h40);
        repeat (2) @(posedge mclk_i);
        chk("bypass source", 8'(mcpc_pkg::SRC_PIN), 8'(src));
        xfer(1'b0, `MCPC_ADDR_LFCTL, 8'h00);
        chk("low freq control", 8'h0f, r & 8'h7f);
        xfer(1'b0, 12'h0f0, 8'h00);
        chk("unmapped error", 8'h01, {7'h0, e});
        $display("test registers done");
        for (int d = 0; d < 8; d++) pulses(d[2:0]);
        $display("test divider done");
        xfer(1'b1, `MCPC_ADDR_LFCTL, 8'h01);
        k = 0;
        do begin
            xfer(1'b0, `MCPC_ADDR_LFCTL, 8'h00);
            k++;
        end while (r[6] !== 1'b1 && k < 20);
        chk("low freq ready", 8'h41, r & 8'h47);
        if (r[6] !== 1'b1) summarize();
        chk("low freq select", 8'h01, {5'h0, lfsel});
        chk("low freq toggles", 8'h01, {7'h0, lf_n != 0});
        $display("test low freq done");
        xfer(1'b1, `MCPC_ADDR_CLKCFG, 8'h80);
        nap(8'h04);
        xfer(1'b0, `MCPC_ADDR_PWRDN, 8'h00);
        chk("wake flags", 8'h84, r);
        chk("no wake reset", 8'h00, 8'(wrst_n));
        xfer(1'b0, `MCPC_ADDR_PWRDN, 8'h00);
        chk("flags cleared", 8'h04, r);
        xfer(1'b1, `MCPC_ADDR_PWRDN, 8'h00);
        xfer(1'b1, `MCPC_ADDR_CLKCFG, 8'h10);
        chk("start deferred", 8'h01, {7'h0, xen});
        nap(8'h01);
        xfer(1'b0, `MCPC_ADDR_PWRDN, 8'h00);
        chk("deep wake flags", 8'h81, r);
        chk("wake reset", 8'h01, 8'(wrst_n));
        chk("crystal off", 8'h00, {7'h0, xen});
        xfer(1'b0, `MCPC_ADDR_LFCTL, 8'h00);
        chk("rc source status", 8'h01, r & 8'h0f);
        $display("test power down done");
        summarize();
    end
endmodule
`default_nettype wire
